// *** src/gtc_timer.sv ***
// module: gated 16-bit timer/counter with avalon-mm register access
`timescale 1ns/1ps
module gtc_timer
   import gtc_pkg::*;
(
   input  wire logic        i_ref_clk,
   input  wire logic        i_sys_rst,
   input  wire logic [7:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   input  wire logic        i_external_count_input,
   input  wire logic        i_crystal_input_pin,
   input  wire logic        i_gate_input_pin,
   input  wire logic        i_comparator_one_output,
   input  wire logic        i_comparator_two_output,
   input  wire logic        i_other_osc_enable,
   input  wire logic        i_sleep,
   input  wire logic [7:0]  i_eight_bit_timer_count,
   input  wire logic [7:0]  i_eight_bit_period_reg,
   output logic [31:0]      o_avs_readdata,
   output logic             o_avs_waitrequest,
   output logic [15:0]      o_count,
   output logic             o_overflow_flag,
   output logic             o_osc_run,
   output logic             o_wake
);
   import gtc_pkg::*;
   // ****************************************
   // declarations
   // ****************************************
   logic [SYNC_PINS-1:0] pins_sync;
   logic        s_ext, s_xtal, s_gpin, s_cmp1, s_cmp2, s_other;
   logic [7:0]  timer_control_reg;
   logic [4:0]  gate_control_reg;
   logic [2:0]  osc_control_two_reg;
   logic [15:0] count_reg;
   logic [7:0]  high_buf_reg;
   logic [1:0]  phase_reg;
   logic        src_prev_reg;
   logic        armed_reg;
   logic        pend_reg;
   logic        gate_hold_reg;
   logic [7:0]  t2_prev_reg;
   logic        ovf_reg;
   logic        osc_reg;
   logic        wake_reg;
   logic        wait_reg;
   logic [31:0] rdata_reg;
   logic        on, osc_en, bypass, wide, gate_en, pol, gate_sync;
   gtc_src_e    cs;
   gtc_gate_e   gss;
   logic        instr_tick, src, ext_rise, ext_fall, raw_tick;
   logic        t2_match, gate_mux, gate_val, gate_active, count_en;
   logic        accept, wr, rd, wr_low, wr_high, wr_count, inc;
   gtc_presc_if pif ();
   // ****************************************
   // pin synchronisers
   // ****************************************
   gtc_sync2 #(.WIDTH(SYNC_PINS)) u_sync (
      .i_ref_clk (i_ref_clk),
      .i_sys_rst (i_sys_rst),
      .i_async   ({i_other_osc_enable, i_comparator_two_output, i_comparator_one_output,
                   i_gate_input_pin, i_crystal_input_pin, i_external_count_input}),
      .o_sync    (pins_sync)
   );
   assign {s_other, s_cmp2, s_cmp1, s_gpin, s_xtal, s_ext} = pins_sync;
   // ****************************************
   // control fields
   // ****************************************
   assign on        = timer_control_reg[TC_ON];
   assign cs        = gtc_src_e'(timer_control_reg[TC_CS +: 2]);
   assign osc_en    = timer_control_reg[TC_OSCEN];
   assign bypass    = timer_control_reg[TC_BYPASS];
   assign wide      = timer_control_reg[TC_WIDE];
   assign gate_en   = gate_control_reg[GC_EN];
   assign pol       = gate_control_reg[GC_POL];
   assign gss       = gtc_gate_e'(gate_control_reg[GC_SS +: 2]);
   assign gate_sync = gate_control_reg[GC_SYNC];
   // ****************************************
   // bus slave: one wait cycle, then answer
   // ****************************************
   assign accept   = (i_avs_read || i_avs_write) && !wait_reg;
   assign wr       = accept && i_avs_write && i_avs_byteenable[0];
   assign rd       = accept && i_avs_read;
   assign wr_low   = wr && (i_avs_address == OFS_COUNT_LOW);
   assign wr_high  = wr && (i_avs_address == OFS_COUNT_HIGH);
   // wide high write only fills buffer
   assign wr_count = wr_low || (wr_high && !wide);
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         wait_reg <= 1'b1;
      end else begin
         wait_reg <= !((i_avs_read || i_avs_write) && wait_reg);
      end
   end
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         rdata_reg <= 32'h0000_0000;
      end else if (i_avs_read && wait_reg) begin
         if (i_avs_address == OFS_COUNT_LOW) begin
            rdata_reg <= {24'h00_0000, count_reg[7:0]};
         end else if (i_avs_address == OFS_COUNT_HIGH) begin
            // wide read returns latched high byte
            rdata_reg <= {24'h00_0000, wide ? high_buf_reg : count_reg[15:8]};
         end else if (i_avs_address == OFS_TIMER_CTRL) begin
            rdata_reg <= {24'h00_0000, timer_control_reg};
         end else if (i_avs_address == OFS_GATE_CTRL) begin
            rdata_reg <= {27'h000_0000, gate_control_reg};
         end else if (i_avs_address == OFS_OSC_CTRL) begin
            rdata_reg <= {29'h0000_0000, osc_control_two_reg};
         end else if (i_avs_address == OFS_STATUS) begin
            rdata_reg <= {30'h0000_0000, osc_reg, ovf_reg};
         end else begin
            rdata_reg <= 32'h0000_0000;
         end
      end
   end
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         timer_control_reg   <= TIMER_CTRL_RST;
         gate_control_reg    <= GATE_CTRL_RST;
         osc_control_two_reg <= OSC_CTRL_RST;
      end else if (wr && i_avs_address == OFS_TIMER_CTRL) begin
         timer_control_reg <= i_avs_writedata[7:0];
      end else if (wr && i_avs_address == OFS_GATE_CTRL) begin
         gate_control_reg <= i_avs_writedata[4:0];
      end else if (wr && i_avs_address == OFS_OSC_CTRL) begin
         osc_control_two_reg <= i_avs_writedata[2:0];
      end
   end
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         high_buf_reg <= 8'h00;
      end else if (wr_high && wide) begin
         high_buf_reg <= i_avs_writedata[7:0];
      end else if (rd && wide && i_avs_address == OFS_COUNT_LOW) begin
         high_buf_reg <= count_reg[15:8];
      end
   end
   // ****************************************
   // clock sources
   // ****************************************
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         phase_reg <= 2'h0;
      end else begin
         phase_reg <= 2'(phase_reg + 2'h1);
      end
   end
   assign instr_tick = (phase_reg == INSTR_PH_LAST) && !i_sleep;
   // enable selects shared oscillator as source
   assign src      = osc_en ? s_xtal : s_ext;
   assign ext_rise = src && !src_prev_reg;
   assign ext_fall = !src && src_prev_reg;
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         src_prev_reg <= 1'b0;
      end else begin
         src_prev_reg <= src;
      end
   end
   // arm on falling edge, disarm on write or disable
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst || wr_count || !on) begin
         armed_reg <= 1'b0;
      end else if (ext_fall) begin
         armed_reg <= 1'b1;
      end
   end
   // pending edge lost on mode switch to bypass
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst || wr_count || !on || bypass) begin
         pend_reg <= 1'b0;
      end else if (ext_rise && armed_reg) begin
         pend_reg <= 1'b1;
      end else if (instr_tick) begin
         pend_reg <= 1'b0;
      end
   end
   always_comb begin
      raw_tick = 1'b0;
      case (cs)
         CS_INSTR:    raw_tick = instr_tick;
         // every system clock, four per instruction
         CS_SYSTEM:   raw_tick = !i_sleep;
         // bypass counts at once, even asleep
         CS_EXTERNAL: raw_tick = bypass ? (ext_rise && armed_reg) : (pend_reg && instr_tick);
         default:     raw_tick = 1'b0;
      endcase
   end
   // ****************************************
   // gate
   // ****************************************
   // wrap from period to zero
   assign t2_match = (t2_prev_reg == i_eight_bit_period_reg) && (i_eight_bit_timer_count == T2_ZERO)
                     && (t2_prev_reg != T2_ZERO);
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         t2_prev_reg <= T2_ZERO;
      end else begin
         t2_prev_reg <= i_eight_bit_timer_count;
      end
   end
   always_comb begin
      gate_mux = s_gpin;
      case (gss)
         GS_PIN:     gate_mux = s_gpin;
         GS_PERIOD:  gate_mux = t2_match;
         GS_CMP_ONE: gate_mux = s_cmp1;
         GS_CMP_TWO: gate_mux = s_cmp2;
         default:    gate_mux = s_gpin;
      endcase
   end
   // pin or comparator gate resampled on timer clock when asked
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         gate_hold_reg <= 1'b0;
      end else if (raw_tick) begin
         gate_hold_reg <= gate_mux;
      end
   end
   assign gate_val    = (gate_sync && gss != GS_PERIOD) ? gate_hold_reg : gate_mux;
   assign gate_active = (gate_val == pol);
   assign count_en    = on && (!gate_en || gate_active);
   // ****************************************
   // prescaler and counter
   // ****************************************
   assign pif.tick_in = raw_tick && count_en;
   // only counter writes clear the prescaler
   assign pif.clear   = wr_count;
   assign pif.sel     = timer_control_reg[TC_PS +: 2];
   gtc_prescale u_presc (
      .i_ref_clk (i_ref_clk),
      .i_sys_rst (i_sys_rst),
      .p         (pif.presc)
   );
   assign inc = pif.tick_out;
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         count_reg <= COUNT_RST;
      end else if (wr_low) begin
         count_reg <= {wide ? high_buf_reg : count_reg[15:8], i_avs_writedata[7:0]};
      end else if (wr_high && !wide) begin
         count_reg <= {i_avs_writedata[7:0], count_reg[7:0]};
      end else if (inc) begin
         count_reg <= 16'(count_reg + 16'h0001);
      end
   end
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         ovf_reg <= 1'b0;
      end else if (inc && count_reg == COUNT_MAX && !wr_count) begin
         ovf_reg <= 1'b1;
      end else if (wr && i_avs_address == OFS_STATUS && i_avs_writedata[ST_OVF]) begin
         ovf_reg <= 1'b0;
      end
   end
   // overflow while asleep wakes the core
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         wake_reg <= 1'b0;
      end else begin
         wake_reg <= inc && count_reg == COUNT_MAX && !wr_count && i_sleep;
      end
   end
   // oscillator run request, unaffected by sleep
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         osc_reg <= 1'b0;
      end else begin
         osc_reg <= osc_en || s_other || osc_control_two_reg[OC_REQ]
                    || (osc_control_two_reg[OC_SCS +: 2] == SCS_LOW_OSC);
      end
   end
   assign o_avs_readdata    = rdata_reg;
   assign o_avs_waitrequest = wait_reg;
   assign o_count           = count_reg;
   assign o_overflow_flag   = ovf_reg;
   assign o_osc_run         = osc_reg;
   assign o_wake            = wake_reg;
   // ****************************************
   // assertions
   // ****************************************
   count_off_hold_a : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      !on && !wr_count |=> $stable(count_reg))
      else $error("counter moved while off");
   sys_rate_a : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (on && !gate_en && cs == CS_SYSTEM && pif.sel == 2'h0 && !i_sleep && !wr_count)
      |=> count_reg == 16'($past(count_reg) + 16'h0001))
      else $error("system clock source did not count every cycle");
   instr_rate_a : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (cs == CS_INSTR && phase_reg != INSTR_PH_LAST) |-> !pif.tick_in)
      else $error("instruction source ticked off phase");
   arm_first_a : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (cs == CS_EXTERNAL && bypass && !armed_reg) |-> !raw_tick)
      else $error("external edge counted before falling edge");
   gate_hold_a : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (gate_en && gate_val != pol && !wr_count) |=> $stable(count_reg))
      else $error("count moved with gate inactive");
   ovf_set_a : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (inc && count_reg == COUNT_MAX && !wr_count) |=> ovf_reg && count_reg == COUNT_RST)
      else $error("rollover did not set overflow");
   wide_load_a : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (wr_low && wide) |=> count_reg == {$past(high_buf_reg), $past(i_avs_writedata[7:0])})
      else $error("wide low write did not load both bytes");
   wide_high_a : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (wr_high && wide && !pif.tick_in) |=> $stable(count_reg) && $stable(u_presc.cnt_reg))
      else $error("wide high write touched counter or prescaler");
   presc_clear_a : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      wr_count |=> u_presc.cnt_reg == 3'h0)
      else $error("counter write left prescaler count");
   osc_run_a : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (osc_en || osc_control_two_reg[OC_REQ]) |=> osc_reg)
      else $error("oscillator not running when requested");
   period_pulse_a : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      t2_match |-> i_eight_bit_timer_count == T2_ZERO ##1 !t2_match)
      else $error("period match pulse malformed");
   bus_answer_a : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_avs_read || i_avs_write) && wait_reg |=> !wait_reg)
      else $error("bus answer later than one cycle");
endmodule

// *** src/gtc_pkg.sv ***
// package: register map, fields, reset values and timing for the gated 16-bit timer
package gtc_pkg;
   // ****************************************
   // register byte offsets
   // ****************************************
   localparam logic [7:0] OFS_COUNT_LOW  = 8'h00;
   localparam logic [7:0] OFS_COUNT_HIGH = 8'h04;
   localparam logic [7:0] OFS_TIMER_CTRL = 8'h08;
   localparam logic [7:0] OFS_GATE_CTRL  = 8'h0c;
   localparam logic [7:0] OFS_OSC_CTRL   = 8'h10;
   localparam logic [7:0] OFS_STATUS     = 8'h14;
   // ****************************************
   // field positions
   // ****************************************
   localparam int TC_ON     = 0;
   localparam int TC_CS     = 1;
   localparam int TC_OSCEN  = 3;
   localparam int TC_PS     = 4;
   localparam int TC_BYPASS = 6;
   localparam int TC_WIDE   = 7;
   localparam int GC_EN     = 0;
   localparam int GC_POL    = 1;
   localparam int GC_SS     = 2;
   localparam int GC_SYNC   = 4;
   localparam int OC_REQ    = 0;
   localparam int OC_SCS    = 1;
   localparam int ST_OVF    = 0;
   localparam int ST_OSC    = 1;
   // ****************************************
   // reset values and encodings
   // ****************************************
   localparam logic [7:0]  TIMER_CTRL_RST = 8'h00;
   localparam logic [4:0]  GATE_CTRL_RST  = 5'h00;
   localparam logic [2:0]  OSC_CTRL_RST   = 3'h0;
   localparam logic [15:0] COUNT_RST      = 16'h0000;
   localparam logic [15:0] COUNT_MAX      = 16'hffff;
   localparam logic [1:0]  SCS_LOW_OSC    = 2'h1;
   localparam logic [7:0]  T2_ZERO        = 8'h00;
   typedef enum logic [1:0] {CS_INSTR, CS_SYSTEM, CS_EXTERNAL, CS_RESERVED} gtc_src_e;
   typedef enum logic [1:0] {GS_PIN, GS_PERIOD, GS_CMP_ONE, GS_CMP_TWO} gtc_gate_e;
   // ****************************************
   // timing
   // ****************************************
   localparam int          CLK_NS        = 5;
   localparam int          INSTR_CLKS    = 4;
   localparam logic [1:0]  INSTR_PH_LAST = 2'(INSTR_CLKS - 1);
   localparam int          SYNC_PINS     = 6;
endpackage

// *** src/gtc_presc_if.sv ***
// interface: tick path between the timer core and its prescaler
`timescale 1ns/1ps
interface gtc_presc_if;
   logic       tick_in;
   logic       clear;
   logic [1:0] sel;
   logic       tick_out;
   modport ctrl  (output tick_in, output clear, output sel, input tick_out);
   modport presc (input tick_in, input clear, input sel, output tick_out);
endinterface

// *** src/gtc_sync2.sv ***
// module: two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module gtc_sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             i_ref_clk,
   input  wire logic             i_sys_rst,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_reg;
   genvar b;
   // ****************************************
   // per-bit chain, first stage read only by the second
   // ****************************************
   for (b = 0; b < WIDTH; b++) begin : g_bit
      always_ff @(posedge i_ref_clk) begin
         if (i_sys_rst) begin
            meta_reg[b] <= 1'b0;
            o_sync[b]   <= 1'b0;
         end else begin
            meta_reg[b] <= i_async[b];
            o_sync[b]   <= meta_reg[b];
         end
      end
   end
endmodule

// *** src/gtc_prescale.sv ***
// module: 1/2/4/8 prescaler with clear, count hidden from software
`timescale 1ns/1ps
module gtc_prescale (
   input  wire logic   i_ref_clk,
   input  wire logic   i_sys_rst,
   gtc_presc_if.presc  p
);
   logic [2:0] cnt_reg;
   logic [2:0] limit;
   assign limit      = 3'((4'h1 << p.sel) - 4'h1);
   // at or past the limit, so a ratio lowered mid-count does not run the count round to wrap
   assign p.tick_out = p.tick_in && (cnt_reg >= limit) && !p.clear;
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst || p.clear) begin
         cnt_reg <= 3'h0;
      end else if (p.tick_in) begin
         cnt_reg <= (cnt_reg >= limit) ? 3'h0 : 3'(cnt_reg + 3'h1);
      end
   end
endmodule

// *** dv/gtc_partner.sv ***
// partner model: count pin, gate pin, comparators and crystal
`timescale 1ns/1ps
module gtc_partner (
   input  wire logic i_ref_clk,
   output logic      o_ext,
   output logic      o_gate,
   output logic      o_cmp_one,
   output logic      o_cmp_two,
   output logic      o_xtal
);
   // comparators and crystal rest low, oscillator not started
   initial begin
      o_ext     = 1'b0;
      o_gate    = 1'b0;
      o_cmp_one = 1'b0;
      o_cmp_two = 1'b0;
      o_xtal    = 1'b0;
   end
   // slow pulses from a low rest level, on the count pin or the crystal
   task automatic pulses(input int n, input logic on_xtal);
      repeat (n) begin
         repeat (10) @(posedge i_ref_clk);
         if (on_xtal) begin
            o_xtal <= 1'b1;
         end else begin
            o_ext <= 1'b1;
         end
         repeat (10) @(posedge i_ref_clk);
         o_xtal <= 1'b0;
         o_ext  <= 1'b0;
      end
   endtask
   // gate level: 0 gate pin, 1 comparator one, else comparator two
   task automatic set_gate(input int which, input logic v);
      @(posedge i_ref_clk);
      if (which == 0) begin
         o_gate <= v;
      end else if (which == 1) begin
         o_cmp_one <= v;
      end else begin
         o_cmp_two <= v;
      end
   endtask
endmodule

// *** dv/tb_gtc_timer.sv ***
// testbench: register access, count rates, gating, pin counting, overflow
`timescale 1ns/1ps
module tb_gtc_timer;
   import gtc_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  adr = 8'h00;
   logic        rd = 1'b0;
   logic        we = 1'b0;
   logic [31:0] wd = 32'h0;
   logic [31:0] rdata;
   logic        wq;
   logic [15:0] cnt;
   logic        ext, gate, c1, c2, xtal;
   logic [7:0]  q[$];
   logic [7:0]  e;
   int          err_count = 0;
   int          cmp_count = 0;
   int          cycles = 0;
   int          seed = 32'ha543;
   logic [31:0] r;
   logic [3:0]  be = 4'h1;
   logic        slp = 1'b0;
   logic [7:0]  t2c = 8'h00;
   logic [7:0]  pr = 8'h00;
   logic        ovf, oscr, wake;
   int          wake_n = 0;
   always #2.5 clk = ~clk;
   gtc_partner p (.i_ref_clk(clk), .o_ext(ext), .o_gate(gate), .o_cmp_one(c1), .o_cmp_two(c2), .o_xtal(xtal));
   gtc_timer dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(we),
      .i_avs_writedata(wd), .i_avs_byteenable(be), .i_external_count_input(ext), .i_crystal_input_pin(xtal),
      .i_gate_input_pin(gate), .i_comparator_one_output(c1), .i_comparator_two_output(c2),
      .i_other_osc_enable(1'b0), .i_sleep(slp), .i_eight_bit_timer_count(t2c),
      .i_eight_bit_period_reg(pr), .o_avs_readdata(rdata), .o_avs_waitrequest(wq), .o_count(cnt),
      .o_overflow_flag(ovf), .o_osc_run(oscr), .o_wake(wake));
   // eight-bit timer beside the block: counts up to its period, then wraps
   always @(posedge clk) begin
      t2c <= (t2c == pr) ? 8'h00 : 8'(t2c + 8'h01);
   end
   always @(posedge clk) begin
      if (wake === 1'b1) begin
         wake_n++;
      end
   end
   // ****************************************
   // checking
   // ****************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      if (err_count == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // read data is only valid at the accepting edge
   always @(posedge clk) begin
      if (rd && wq === 1'b0) begin
         e = (q.size() > 0) ? q.pop_front() : 8'hxx;
         chk({8'h00, rdata[7:0]}, {8'h00, e});
      end
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles > 20000) begin
         err_count++;
         report_and_stop();
      end
   end
   // ****************************************
   // stimulus
   // ****************************************
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      rd  <= !w;
      we  <= w;
      adr <= a;
      wd  <= {24'h0, d};
      do @(posedge clk); while (wq !== 1'b0);
      rd <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic rdx(input logic [7:0] a, input logic [7:0] exp);
      q.push_back(exp);
      bus(1'b0, a, 8'h00);
   endtask
   // counts gained over n cycles of a running timer
   task automatic rate(input int n, input logic [15:0] exp);
      logic [15:0] c0;
      repeat (6) @(negedge clk);
      c0 = cnt;
      repeat (n) @(negedge clk);
      chk(cnt - c0, exp);
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rdx(OFS_COUNT_LOW, 8'h00); // reset value
      rdx(OFS_STATUS, 8'h00); // flag clear
      rdx(8'h20, 8'h00); // unmapped reads zero
      r = $random(seed);
      bus(1'b1, OFS_COUNT_LOW, r[7:0]);
      rdx(OFS_COUNT_LOW, r[7:0]);
      // write without byte lane 0 is ignored
      be <= 4'h0;
      bus(1'b1, OFS_COUNT_LOW, ~r[7:0]);
      be <= 4'h1;
      rdx(OFS_COUNT_LOW, r[7:0]);
      // system clock with each prescale ratio
      for (int ps = 0; ps < 4; ps++) begin
         bus(1'b1, OFS_TIMER_CTRL, 8'h03 | 8'(ps << 4));
         rate(8 << ps, 16'd8);
      end
      bus(1'b1, OFS_TIMER_CTRL, 8'h11);
      rate(64, 16'd8);
      bus(1'b1, OFS_TIMER_CTRL, 8'h00);
      rate(16, 16'd0);
      bus(1'b1, OFS_TIMER_CTRL, 8'h03);
      bus(1'b1, OFS_GATE_CTRL, 8'h03);
      rate(16, 16'd0);
      p.set_gate(0, 1'b1);
      rate(16, 16'd16);
      bus(1'b1, OFS_GATE_CTRL, 8'h01);
      rate(16, 16'd0);
      // comparators and period match as gate sources
      bus(1'b1, OFS_GATE_CTRL, 8'h1f);
      rate(16, 16'd0);
      p.set_gate(2, 1'b1);
      rate(16, 16'd16);
      bus(1'b1, OFS_GATE_CTRL, 8'h0b);
      rate(16, 16'd0);
      p.set_gate(1, 1'b1);
      rate(16, 16'd16);
      pr <= 8'h07;
      bus(1'b1, OFS_GATE_CTRL, 8'h07);
      rate(64, 16'd8);
      bus(1'b1, OFS_GATE_CTRL, 8'h00);
      // stop before writing; rollover sets flag
      bus(1'b1, OFS_TIMER_CTRL, 8'h00);
      bus(1'b1, OFS_COUNT_LOW, 8'hff);
      bus(1'b1, OFS_COUNT_HIGH, 8'hff);
      bus(1'b1, OFS_TIMER_CTRL, 8'h03);
      bus(1'b1, OFS_TIMER_CTRL, 8'h00);
      rdx(OFS_STATUS, 8'h01);
      bus(1'b1, OFS_STATUS, 8'h01);
      rdx(OFS_STATUS, 8'h00);
      // first rise after a write is not counted
      bus(1'b1, OFS_COUNT_HIGH, 8'h00);
      bus(1'b1, OFS_COUNT_LOW, 8'h00);
      bus(1'b1, OFS_TIMER_CTRL, 8'h45);
      p.pulses(5, 1'b0);
      repeat (8) @(posedge clk);
      rdx(OFS_COUNT_LOW, 8'h04);
      bus(1'b1, OFS_TIMER_CTRL, 8'h80);
      bus(1'b1, OFS_COUNT_HIGH, 8'h12);
      @(negedge clk);
      chk(cnt, 16'h0004); // high write only buffered
      bus(1'b1, OFS_COUNT_LOW, 8'h34);
      @(negedge clk);
      chk(cnt, 16'h1234);
      rdx(OFS_COUNT_LOW, 8'h34);
      rdx(OFS_COUNT_HIGH, 8'h12);
      // bypassed pin counts through rollover while asleep, one wake pulse
      bus(1'b1, OFS_TIMER_CTRL, 8'h00);
      bus(1'b1, OFS_COUNT_HIGH, 8'hff);
      bus(1'b1, OFS_COUNT_LOW, 8'hfe);
      bus(1'b1, OFS_TIMER_CTRL, 8'h45);
      slp <= 1'b1;
      p.pulses(4, 1'b0);
      repeat (8) @(posedge clk);
      slp <= 1'b0;
      @(negedge clk);
      chk(cnt, 16'h0001);
      chk({15'h0000, ovf}, 16'h0001);
      chk(16'(wake_n), 16'h0001);
      bus(1'b1, OFS_STATUS, 8'h01);
      // oscillator enabled and left to settle before the timer starts
      bus(1'b1, OFS_TIMER_CTRL, 8'h4c);
      bus(1'b1, OFS_COUNT_LOW, 8'h00);
      repeat (20) @(posedge clk);
      bus(1'b1, OFS_TIMER_CTRL, 8'h4d);
      p.pulses(3, 1'b1);
      repeat (8) @(posedge clk);
      @(negedge clk);
      chk(cnt, 16'h0002);
      chk({15'h0000, oscr}, 16'h0001);
      bus(1'b1, OFS_OSC_CTRL, 8'h01);
      repeat (4) @(posedge clk);
      rdx(OFS_STATUS, 8'h02);
      repeat (4) @(posedge clk);
      report_and_stop();
   end
endmodule
